/* verilog/brownout_poweron_monitor.sv */
// Top of the supply monitor: register slave, flags, modes and outputs
//
// Notes on behaviour
// RQ1 - A reset-level trip asserts the processor reset in every mode but total power-down and cannot be switched off.
// RQ2 - Reset and interrupt trips each have their own two-bit selection of three levels.
// RQ3 - Selection pairs decode to 2.2/2.4/3.0 V reset with the listed interrupt levels; other pairs are reserved.
// RQ4 - Software is expected to set the reset level below the interrupt level.
// RQ5 - Power mode 11 disables all brownout detection, so no reset or interrupt trip occurs.
// RQ6 - The brownout interrupt needs a live mode, the arm bit, the source enable and the global enable.
// RQ7 - The brownout reset flag is bit 5 of the reset-source register, clear after reset, set on a reset trip.
// RQ8 - The brownout interrupt flag is bit 6 of the reset-source register, clear after reset, set on an interrupt trip.
// RQ9 - The flash monitor runs whenever the upper mode bit is 0 and cannot be switched off.
// RQ10 - The flash monitor trips at 2.4 V and blocks program and erase while below it.
// RQ11 - An enabled condition follows the supply: asserted below the trip, negated above it.
// RQ12 - The power-on flag is bit 4, set on power-up and held until software writes 0.
// RQ13 - Setting the power-on flag also sets the brownout reset flag.
// RQ14 - The power mode is a two-bit field, 00 normal by default.
// RQ15 - Idle mode 01 is left on any enabled interrupt or any reset.
// RQ16 - Mode 10 stops the oscillator; mode 11 also turns off detection and comparators.
// RQ17 - The interrupt flag stays set until written 0 and keeps the request pending while enabled.
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module brownout_poweron_monitor (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic ce, // Clock enable, state frozen while low
	input wire logic [7:0] awaddr, // Write address
	input wire logic awvalid, // Write address valid
	output logic awready, // Write address ready
	input wire logic [31:0] wdata, // Write data
	input wire logic [3:0] wstrb, // Write byte strobes
	input wire logic wvalid, // Write data valid
	output logic wready, // Write data ready
	output logic [1:0] bresp, // Write response
	output logic bvalid, // Write response valid
	input wire logic bready, // Write response ready
	input wire logic [7:0] araddr, // Read address
	input wire logic arvalid, // Read address valid
	output logic arready, // Read address ready
	output logic [31:0] rdata, // Read data
	output logic [1:0] rresp, // Read response
	output logic rvalid, // Read data valid
	input wire logic rready, // Read data ready
	input wire logic [4:0] vdd_below, // Comparators, high while below
	input wire logic poweron_det, // Power-on detector, high at power-up
	input wire logic wake_irq, // Any other enabled interrupt
	output logic cpu_reset_req, // Processor reset request
	output logic flash_block, // Blocks flash program and erase
	output logic brownout_irq_req, // Brownout interrupt request
	output logic irq, // Event interrupt, level
	output logic [1:0] pwr_mode, // Current power mode
	output logic osc_stop, // Stop the oscillator
	output logic cmp_disable // Turn off voltage comparators
);

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	// Word-align a byte address; low two bits are ignored
	function automatic logic [7:0] word_of(input logic [7:0] a);
		word_of = {a[7:2], 2'b00};
	endfunction

	// True for every implemented register word
	function automatic logic mapped(input logic [7:0] w);
		mapped = (w == pwr_mon_pkg::OFS_PWR_CTRL) ||
			(w == pwr_mon_pkg::OFS_IRQ_CFG) ||
			(w == pwr_mon_pkg::OFS_USER_CFG) ||
			(w == pwr_mon_pkg::OFS_IRQ_EN) ||
			(w == pwr_mon_pkg::OFS_RST_SRC) ||
			(w == pwr_mon_pkg::OFS_EVT_STAT) ||
			(w == pwr_mon_pkg::OFS_EVT_MASK) ||
			(w == pwr_mon_pkg::OFS_MON_STAT);
	endfunction

	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	pwr_mon_pkg::wr_state_t wr_state_reg;
	pwr_mon_pkg::rd_state_t rd_state_reg;
	pwr_mon_pkg::pwr_mode_t pmode_reg;
	pwr_mon_pkg::pwr_mode_t pmode_next;
	logic aw_have_reg;
	logic w_have_reg;
	logic [7:0] aw_word_reg;
	logic [7:0] w_byte_reg;
	logic w_lane_reg;
	logic irq_arm_reg;
	logic [1:0] isel_reg;
	logic [1:0] rsel_reg;
	logic src_en_reg;
	logic gie_reg;
	logic pof_reg;
	logic bof_reg;
	logic brownout_irq_flag_reg;
	logic por_prev_reg;
	logic [3:0] evt_stat_reg;
	logic [3:0] evt_mask_reg;
	logic [7:0] rd_byte;
	logic [7:0] byte_pwr;
	logic [7:0] byte_user;
	logic [7:0] byte_ien;
	logic [7:0] byte_src;
	logic [7:0] byte_mon;

	bo_if bus();

	// --------------------------------------------------------------
	// Decode and detection
	// --------------------------------------------------------------
	assign bus.pwr_mode = pmode_reg;
	assign bus.rst_sel = rsel_reg;
	assign bus.irq_sel = isel_reg;
	assign bus.irq_arm = irq_arm_reg;
	assign bus.vdd_below = vdd_below;

	trip_level_select u_sel (
		.bus(bus)
	);

	brownout_detector u_det (
		.bus(bus)
	);

	// --------------------------------------------------------------
	// Bus handshakes and write strobes
	// --------------------------------------------------------------
	wire aw_take;
	wire w_take;
	wire ar_take;
	wire wr_fire;
	wire wr_en;
	wire wr_pwr;
	wire wr_icfg;
	wire wr_user;
	wire wr_ien;
	wire wr_src;
	wire wr_mask;
	wire [7:0] ar_word;
	wire stat_rd_clr;
	assign aw_take = awvalid & awready;
	assign w_take = wvalid & wready;
	assign ar_take = arvalid & arready;
	assign wr_fire = (wr_state_reg == pwr_mon_pkg::WR_IDLE) &
		aw_have_reg & w_have_reg;
	// Every field lives in byte lane 0, so only that strobe matters
	assign wr_en = wr_fire & w_lane_reg;
	assign wr_pwr = wr_en & (aw_word_reg == pwr_mon_pkg::OFS_PWR_CTRL);
	assign wr_icfg = wr_en & (aw_word_reg == pwr_mon_pkg::OFS_IRQ_CFG);
	assign wr_user = wr_en & (aw_word_reg == pwr_mon_pkg::OFS_USER_CFG);
	assign wr_ien = wr_en & (aw_word_reg == pwr_mon_pkg::OFS_IRQ_EN);
	assign wr_src = wr_en & (aw_word_reg == pwr_mon_pkg::OFS_RST_SRC);
	assign wr_mask = wr_en & (aw_word_reg == pwr_mon_pkg::OFS_EVT_MASK);
	assign ar_word = word_of(araddr);
	assign stat_rd_clr = ar_take & (ar_word == pwr_mon_pkg::OFS_EVT_STAT);

	// --------------------------------------------------------------
	// Flag and mode next values
	// --------------------------------------------------------------
	wire pof_next;
	wire bof_next;
	wire brownout_irq_flag_next;
	wire idle_wake;
	wire brq_next;
	wire [3:0] evt_set;
	wire [3:0] evt_stat_next;
	// Set terms are ORed after the clear, so a trip in the clearing
	// cycle survives
	assign pof_next = poweron_det | (pof_reg &
		~(wr_src & ~w_byte_reg[pwr_mon_pkg::BIT_POF])); // [RQ12]
	assign bof_next = bus.rst_cond | poweron_det | (bof_reg &
		~(wr_src & ~w_byte_reg[pwr_mon_pkg::BIT_BOF])); // [RQ7] [RQ13]
	assign brownout_irq_flag_next = bus.irq_cond | (brownout_irq_flag_reg &
		~(wr_src & ~w_byte_reg[pwr_mon_pkg::BIT_BROWNOUT_IRQ_FLAG])); // [RQ8] [RQ17]
	// Pending flag keeps the request up while all enables hold
	assign brq_next = brownout_irq_flag_reg & irq_arm_reg & src_en_reg & gie_reg &
		(pmode_reg != pwr_mon_pkg::PM_TOTAL_DOWN); // [RQ6] [RQ17]
	assign idle_wake = (pmode_reg == pwr_mon_pkg::PM_IDLE) &
		(wake_irq | brownout_irq_req | irq); // [RQ15]
	// A software write wins over a wake or a brownout reset in the same cycle;
	// otherwise a brownout reset returns the mode to normal like any other reset
	assign pmode_next = wr_pwr ? pwr_mon_pkg::pwr_mode_t'(
		w_byte_reg[pwr_mon_pkg::BIT_PMODE_HI:pwr_mon_pkg::BIT_PMODE_LO]) :
		(idle_wake | bus.rst_cond) ? pwr_mon_pkg::PM_NORMAL :
		pmode_reg; // [RQ14] [RQ15]
	// Events are rising edges of the reset and flash conditions and poweron_det; the irq event sets while its flag is clear
	assign evt_set = {poweron_det & ~por_prev_reg,
		bus.flash_cond & ~flash_block,
		bus.irq_cond & ~brownout_irq_flag_reg,
		bus.rst_cond & ~cpu_reset_req};
	assign evt_stat_next = evt_set |
		(evt_stat_reg & ~{pwr_mon_pkg::NUM_EVT{stat_rd_clr}});

	// --------------------------------------------------------------
	// Read data bytes
	// --------------------------------------------------------------
	always_comb
	begin
		byte_pwr = 8'h00;
		byte_pwr[pwr_mon_pkg::BIT_PMODE_HI:pwr_mon_pkg::BIT_PMODE_LO] =
			pmode_reg;
		byte_pwr[pwr_mon_pkg::BIT_IRQ_ARM] = irq_arm_reg;
		byte_user = 8'h00;
		byte_user[pwr_mon_pkg::BIT_RSEL_HI] = rsel_reg[1];
		byte_user[pwr_mon_pkg::BIT_RSEL_LO] = rsel_reg[0];
		byte_ien = 8'h00;
		byte_ien[pwr_mon_pkg::BIT_SRC_EN] = src_en_reg;
		byte_ien[pwr_mon_pkg::BIT_GIE] = gie_reg;
		byte_src = 8'h00;
		byte_src[pwr_mon_pkg::BIT_POF] = pof_reg;
		byte_src[pwr_mon_pkg::BIT_BOF] = bof_reg;
		byte_src[pwr_mon_pkg::BIT_BROWNOUT_IRQ_FLAG] = brownout_irq_flag_reg;
		byte_mon = 8'h00;
		byte_mon[pwr_mon_pkg::BIT_MON_RST] = bus.rst_cond;
		byte_mon[pwr_mon_pkg::BIT_MON_IRQ] = bus.irq_cond;
		byte_mon[pwr_mon_pkg::BIT_MON_FLASH] = bus.flash_cond;
		byte_mon[pwr_mon_pkg::BIT_MON_RSVD] = bus.cfg_reserved;
	end

	// Unmapped words read as zero
	assign rd_byte =
		(ar_word == pwr_mon_pkg::OFS_PWR_CTRL) ? byte_pwr :
		(ar_word == pwr_mon_pkg::OFS_IRQ_CFG) ? {6'h00, isel_reg} :
		(ar_word == pwr_mon_pkg::OFS_USER_CFG) ? byte_user :
		(ar_word == pwr_mon_pkg::OFS_IRQ_EN) ? byte_ien :
		(ar_word == pwr_mon_pkg::OFS_RST_SRC) ? byte_src :
		(ar_word == pwr_mon_pkg::OFS_EVT_STAT) ? {4'h0, evt_stat_reg} :
		(ar_word == pwr_mon_pkg::OFS_EVT_MASK) ? {4'h0, evt_mask_reg} :
		(ar_word == pwr_mon_pkg::OFS_MON_STAT) ? byte_mon : 8'h00;

	// --------------------------------------------------------------
	// Write channel: address and data taken in either order
	// --------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_state_reg <= pwr_mon_pkg::WR_IDLE;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= pwr_mon_pkg::RESP_OKAY;
			aw_word_reg <= 8'h00;
			w_byte_reg <= 8'h00;
			w_lane_reg <= 1'b0;
		end
		else if (ce)
		begin
			case (wr_state_reg)
			pwr_mon_pkg::WR_IDLE:
			begin
				if (aw_take)
				begin
					aw_have_reg <= 1'b1;
					awready <= 1'b0;
					aw_word_reg <= word_of(awaddr);
				end
				else if (!aw_have_reg)
					awready <= 1'b1;
				if (w_take)
				begin
					w_have_reg <= 1'b1;
					wready <= 1'b0;
					w_byte_reg <= wdata[7:0];
					w_lane_reg <= wstrb[0];
				end
				else if (!w_have_reg)
					wready <= 1'b1;
				if (wr_fire)
				begin
					wr_state_reg <= pwr_mon_pkg::WR_RESP;
					bvalid <= 1'b1;
					bresp <= mapped(aw_word_reg) ?
						pwr_mon_pkg::RESP_OKAY : pwr_mon_pkg::RESP_DECERR;
				end
			end
			pwr_mon_pkg::WR_RESP:
			begin
				if (bready)
				begin
					wr_state_reg <= pwr_mon_pkg::WR_IDLE;
					bvalid <= 1'b0;
					aw_have_reg <= 1'b0;
					w_have_reg <= 1'b0;
					awready <= 1'b1;
					wready <= 1'b1;
				end
			end
			default:
				wr_state_reg <= pwr_mon_pkg::WR_IDLE;
			endcase
		end
	end

	// --------------------------------------------------------------
	// Read channel: data is sampled at the address edge
	// --------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rd_state_reg <= pwr_mon_pkg::RD_IDLE;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= pwr_mon_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			case (rd_state_reg)
			pwr_mon_pkg::RD_IDLE:
			begin
				if (ar_take)
				begin
					rd_state_reg <= pwr_mon_pkg::RD_RESP;
					arready <= 1'b0;
					rvalid <= 1'b1;
					rdata <= {24'h000000, rd_byte};
					rresp <= mapped(ar_word) ?
						pwr_mon_pkg::RESP_OKAY : pwr_mon_pkg::RESP_DECERR;
				end
				else
					arready <= 1'b1;
			end
			pwr_mon_pkg::RD_RESP:
			begin
				if (rready)
				begin
					rd_state_reg <= pwr_mon_pkg::RD_IDLE;
					rvalid <= 1'b0;
					arready <= 1'b1;
				end
			end
			default:
				rd_state_reg <= pwr_mon_pkg::RD_IDLE;
			endcase
		end
	end

	// --------------------------------------------------------------
	// Control registers
	// --------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pmode_reg <= pwr_mon_pkg::PM_NORMAL; // [RQ14]
			irq_arm_reg <= 1'b0;
			isel_reg <= pwr_mon_pkg::RST_ISEL;
			rsel_reg <= pwr_mon_pkg::RST_RSEL;
			src_en_reg <= 1'b0;
			gie_reg <= 1'b0;
			evt_mask_reg <= pwr_mon_pkg::RST_EVT_MASK;
		end
		else if (ce)
		begin
			pmode_reg <= pmode_next;
			if (wr_pwr)
				irq_arm_reg <= w_byte_reg[pwr_mon_pkg::BIT_IRQ_ARM];
			if (wr_icfg)
				isel_reg <= w_byte_reg[pwr_mon_pkg::BIT_ISEL_HI:
					pwr_mon_pkg::BIT_ISEL_LO]; // [RQ2]
			if (wr_user)
				rsel_reg <= {w_byte_reg[pwr_mon_pkg::BIT_RSEL_HI],
					w_byte_reg[pwr_mon_pkg::BIT_RSEL_LO]}; // [RQ2]
			if (wr_ien)
			begin
				src_en_reg <= w_byte_reg[pwr_mon_pkg::BIT_SRC_EN];
				gie_reg <= w_byte_reg[pwr_mon_pkg::BIT_GIE];
			end
			if (wr_mask)
				evt_mask_reg <= w_byte_reg[3:0];
		end
	end

	// --------------------------------------------------------------
	// Flags, events and outputs
	// --------------------------------------------------------------
	// The reset request is not fed back into this block's own reset,
	// so flags survive the brownout reset they record
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pof_reg <= 1'b0;
			bof_reg <= 1'b0; // [RQ7]
			brownout_irq_flag_reg <= 1'b0; // [RQ8]
			por_prev_reg <= 1'b0;
			evt_stat_reg <= 4'h0;
			cpu_reset_req <= 1'b0;
			flash_block <= 1'b0;
			brownout_irq_req <= 1'b0;
			irq <= 1'b0;
			pwr_mode <= 2'h0;
			osc_stop <= 1'b0;
			cmp_disable <= 1'b0;
		end
		else if (ce)
		begin
			pof_reg <= pof_next;
			bof_reg <= bof_next;
			brownout_irq_flag_reg <= brownout_irq_flag_next;
			por_prev_reg <= poweron_det;
			evt_stat_reg <= evt_stat_next;
			cpu_reset_req <= bus.rst_cond; // [RQ1]
			flash_block <= bus.flash_cond; // [RQ10]
			brownout_irq_req <= brq_next; // [RQ6]
			irq <= |(evt_stat_reg & evt_mask_reg);
			pwr_mode <= pmode_reg;
			osc_stop <= pmode_reg[1]; // [RQ16]
			cmp_disable <= pmode_reg == pwr_mon_pkg::PM_TOTAL_DOWN; // [RQ16]
		end
	end

endmodule

/* shared/pwr_mon_pkg.sv */
// Shared constants and types for the supply monitor block
package pwr_mon_pkg;

	// --------------------------------------------------------------
	// Register byte offsets
	// --------------------------------------------------------------
	localparam logic [7:0] OFS_PWR_CTRL = 8'h00;
	localparam logic [7:0] OFS_IRQ_CFG = 8'h04;
	localparam logic [7:0] OFS_USER_CFG = 8'h08;
	localparam logic [7:0] OFS_IRQ_EN = 8'h0C;
	localparam logic [7:0] OFS_RST_SRC = 8'h10;
	localparam logic [7:0] OFS_EVT_STAT = 8'h14;
	localparam logic [7:0] OFS_EVT_MASK = 8'h18;
	localparam logic [7:0] OFS_MON_STAT = 8'h1C;

	// --------------------------------------------------------------
	// Field positions inside the low byte of each register
	// --------------------------------------------------------------
	localparam int BIT_PMODE_LO = 0;
	localparam int BIT_PMODE_HI = 1;
	localparam int BIT_IRQ_ARM = 4;
	localparam int BIT_ISEL_LO = 0;
	localparam int BIT_ISEL_HI = 1;
	localparam int BIT_RSEL_LO = 3;
	localparam int BIT_RSEL_HI = 5;
	localparam int BIT_SRC_EN = 5;
	localparam int BIT_GIE = 7;
	localparam int BIT_POF = 4;
	localparam int BIT_BOF = 5;
	localparam int BIT_BROWNOUT_IRQ_FLAG = 6;
	localparam int BIT_MON_RST = 0;
	localparam int BIT_MON_IRQ = 1;
	localparam int BIT_MON_FLASH = 2;
	localparam int BIT_MON_RSVD = 3;

	// --------------------------------------------------------------
	// Reset values
	// --------------------------------------------------------------
	localparam logic [1:0] RST_ISEL = 2'h1;
	localparam logic [1:0] RST_RSEL = 2'h1;
	localparam logic [3:0] RST_EVT_MASK = 4'h0;

	// --------------------------------------------------------------
	// Trip selection codes and level indices
	// --------------------------------------------------------------
	localparam logic [1:0] SEL_NONE = 2'h0;
	localparam logic [1:0] RSEL_2V4 = 2'h2;
	localparam logic [1:0] RSEL_3V0 = 2'h3;
	localparam logic [1:0] ISEL_2V6 = 2'h2;
	localparam logic [1:0] ISEL_3V2 = 2'h3;
	localparam int NUM_LVL = 5;
	localparam logic [2:0] LVL_2V2 = 3'h0;
	localparam logic [2:0] LVL_2V4 = 3'h1;
	localparam logic [2:0] LVL_2V6 = 3'h2;
	localparam logic [2:0] LVL_3V0 = 3'h3;
	localparam logic [2:0] LVL_3V2 = 3'h4;

	// --------------------------------------------------------------
	// Event status bits
	// --------------------------------------------------------------
	localparam int NUM_EVT = 4;
	localparam int EVT_RST = 0;
	localparam int EVT_IRQ = 1;
	localparam int EVT_FLASH = 2;
	localparam int EVT_POR = 3;

	// --------------------------------------------------------------
	// Bus answers and types
	// --------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {
		PM_NORMAL = 2'b00,
		PM_IDLE = 2'b01,
		PM_DOWN = 2'b10,
		PM_TOTAL_DOWN = 2'b11
	} pwr_mode_t;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b01,
		WR_RESP = 2'b10
	} wr_state_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_RESP = 2'b10
	} rd_state_t;

endpackage

/* shared/bo_if.sv */
// Interface joining the monitor top to its decode and detector parts
`timescale 1ns/1ps
interface bo_if;
	logic [1:0] pwr_mode;
	logic [1:0] rst_sel;
	logic [1:0] irq_sel;
	logic irq_arm;
	logic [pwr_mon_pkg::NUM_LVL-1:0] vdd_below;
	logic [2:0] rst_lvl;
	logic [2:0] irq_lvl;
	logic irq_lvl_ok;
	logic cfg_reserved;
	logic rst_cond;
	logic irq_cond;
	logic flash_cond;

	modport top (
		output pwr_mode, rst_sel, irq_sel, irq_arm, vdd_below,
		input rst_lvl, irq_lvl, irq_lvl_ok, cfg_reserved,
		input rst_cond, irq_cond, flash_cond
	);
	modport sel (
		input rst_sel, irq_sel,
		output rst_lvl, irq_lvl, irq_lvl_ok, cfg_reserved
	);
	modport det (
		input pwr_mode, irq_arm, vdd_below, rst_lvl, irq_lvl, irq_lvl_ok,
		output rst_cond, irq_cond, flash_cond
	);
endinterface

/* verilog/trip_level_select.sv */
// Decode of the two trip selection pairs into comparator level indices
`timescale 1ns/1ps
module trip_level_select (
	bo_if.sel bus // Selection bits in, level indices out
);

	// --------------------------------------------------------------
	// Reset level
	// --------------------------------------------------------------
	// Code 00 falls back to the lowest trip so reset can never be lost
	assign bus.rst_lvl = (bus.rst_sel == pwr_mon_pkg::RSEL_3V0) ?
		pwr_mon_pkg::LVL_3V0 : (bus.rst_sel == pwr_mon_pkg::RSEL_2V4) ?
		pwr_mon_pkg::LVL_2V4 : pwr_mon_pkg::LVL_2V2; // [RQ2] [RQ3] [RQ1]

	// --------------------------------------------------------------
	// Interrupt level
	// --------------------------------------------------------------
	// Valid pairs are exactly those where the interrupt code is not
	// below the reset code and the reset code is not 00
	assign bus.irq_lvl_ok = (bus.rst_sel != pwr_mon_pkg::SEL_NONE) &&
		(bus.irq_sel >= bus.rst_sel); // [RQ3]
	assign bus.irq_lvl = (bus.irq_sel == pwr_mon_pkg::ISEL_3V2) ?
		pwr_mon_pkg::LVL_3V2 : (bus.irq_sel == pwr_mon_pkg::ISEL_2V6) ?
		pwr_mon_pkg::LVL_2V6 : pwr_mon_pkg::LVL_2V4; // [RQ2] [RQ3]
	assign bus.cfg_reserved = ~bus.irq_lvl_ok; // [RQ3]

endmodule

/* verilog/brownout_detector.sv */
// Gating of the comparator trips by power mode and arming
`timescale 1ns/1ps
module brownout_detector (
	bo_if.det bus // Mode and levels in, live conditions out
);

	// Pick one comparator output by level index
	function automatic logic below_at(
		input logic [pwr_mon_pkg::NUM_LVL-1:0] v,
		input logic [2:0] lvl
	);
		below_at = v[lvl];
	endfunction

	// --------------------------------------------------------------
	// Monitor enables
	// --------------------------------------------------------------
	wire monitor_on;
	wire flash_on;
	assign monitor_on = bus.pwr_mode != pwr_mon_pkg::PM_TOTAL_DOWN; // [RQ5]
	assign flash_on = ~bus.pwr_mode[1]; // [RQ9]

	// --------------------------------------------------------------
	// Conditions follow the comparators both ways, no latching here
	// --------------------------------------------------------------
	assign bus.rst_cond = monitor_on &
		below_at(bus.vdd_below, bus.rst_lvl); // [RQ1] [RQ11]
	assign bus.irq_cond = monitor_on & bus.irq_arm & bus.irq_lvl_ok &
		below_at(bus.vdd_below, bus.irq_lvl); // [RQ11] [RQ6]
	assign bus.flash_cond = flash_on &
		below_at(bus.vdd_below, pwr_mon_pkg::LVL_2V4); // [RQ10]

endmodule

/* bench/monitor_asserts.sv */
// Port checker for the supply monitor top
`timescale 1ns/1ps
module monitor_asserts (
	input wire logic aclk, aresetn, awvalid, awready, wvalid, wready,
	input wire logic bvalid, arvalid, arready, rvalid, wake_irq,
	input wire logic [4:0] vdd_below,
	input wire logic cpu_reset_req, flash_block, brownout_irq_req,
	input wire logic [1:0] pwr_mode,
	input wire logic osc_stop, cmp_disable
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----------------------------------------
	// Bus answers: write two edges, read one edge after taking
	// ----------------------------------------
	sequence wr_taken; awvalid && awready && wvalid && wready; endsequence
	sequence rd_taken; arvalid && arready; endsequence
	// The write fires one cycle after both halves are taken, then answers
	wr_resp_a: assert property (wr_taken |-> ##2 bvalid)
		else $error("write answer missing");
	rd_resp_a: assert property (rd_taken |=> rvalid)
		else $error("read answer missing");
	// ----------------------------------------
	// Monitor outputs, one clock behind the supply, in step with pwr_mode
	// ----------------------------------------
	rst_follow_a: assert property ($past(aresetn) &&
		$past(vdd_below) == 5'h1F && pwr_mode != 2'h3 |-> cpu_reset_req)
		else $error("reset trip not passed on");
	total_rst_a: assert property (pwr_mode == 2'h3 |-> !cpu_reset_req)
		else $error("reset trip in total power-down");
	total_irq_a: assert property (pwr_mode == 2'h3 |-> !brownout_irq_req)
		else $error("interrupt in total power-down");
	flash_gate_a: assert property ($past(aresetn) |->
		flash_block == ($past(vdd_below[1]) && !pwr_mode[1]))
		else $error("flash block wrong");
	mode_out_a: assert property (osc_stop == pwr_mode[1] &&
		cmp_disable == (pwr_mode == 2'h3))
		else $error("mode outputs wrong");
	// Idle is left within three clocks of a wake request
	idle_wake_a: assert property (pwr_mode == 2'h1 && wake_irq
		|-> ##[1:3] pwr_mode == 2'h0)
		else $error("idle not left");
endmodule
bind brownout_poweron_monitor monitor_asserts u_chk (.*);

/* bench/brownout_poweron_monitor_tb.sv */
// Self-checking bench for the supply monitor
`timescale 1ns/1ps
module brownout_poweron_monitor_tb;
	logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0, poweron_det = 1'h0, wake_irq = 1'h0;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic [3:0] wstrb = 4'hF;
	logic [4:0] vdd_below = 5'h0;
	logic awready, wready, bvalid, arready, rvalid, cpu_reset_req, irq;
	logic flash_block, brownout_irq_req, osc_stop, cmp_disable;
	logic [1:0] bresp, rresp, pwr_mode, rs;
	logic [2:0] e;
	int n_mismatch = 0, cmp_count = 0, lv, brownout_rst_flag, brownout_irq_flag;
	// Clock of 40 ns
	always #20 aclk = ~aclk;
	brownout_poweron_monitor u_brownout_poweron_monitor (.*);
	task automatic chk(input string nm, input logic [31:0] s, ex);
		cmp_count++;
		if (s !== ex)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, ex, s);
		end
	endtask
	task automatic test_done;
		if (n_mismatch == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Write: both channels offered together, bready held until answer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (i = 0; i < 40 && !bvalid; i++)
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'h0;
			if (wready)
				wvalid <= 1'h0;
		end
		bready <= 1'h0;
		rs = bresp;
		// A write that never answers counts against the run
		if (i == 40)
		begin
			n_mismatch++;
			test_done;
		end
	endtask
	task automatic rdr(input logic [7:0] a);
		int i;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (i = 0; i < 40 && !rvalid; i++)
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'h0;
		end
		rready <= 1'h0;
		rd = rdata;
		rs = rresp;
		// A read that never answers counts against the run
		if (i == 40)
		begin
			n_mismatch++;
			test_done;
		end
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, logic [31:0] ex);
		rdr(a);
		chk(nm, rd, ex);
	endtask
	// Model of live conditions: vdd_below[k] high for k >= lv
	function automatic logic [2:0] live(input int c, input int l);
		int r, i;
		r = c[3:2] == 3 ? 3 : c[3:2] - 1;
		i = c[1:0] == 3 ? 4 : c[1:0];
		live = {l <= 1, c[1:0] != 0 && c[1:0] >= c[3:2] && l <= i, l <= r};
	endfunction
	initial
	begin
		void'($urandom(13177));
		tick(12);
		aresetn <= 1'h1;
		tick(1);
		rchk("pwr", 8'h00, 32'h0);
		rchk("ucfg", 8'h08, 32'h8);
		rchk("rsrc", 8'h10, 32'h0);
		wr(8'h0C, 32'hA0);
		wr(8'h00, 32'h10);
		brownout_rst_flag = 0;
		brownout_irq_flag = 0;
		// Every selection pair with reset code not 00, random supply level
		for (int c = 4; c < 16; c++)
		begin
			wr(8'h08, {26'h0, c[3], 1'h0, c[2], 3'h0});
			wr(8'h04, {30'h0, c[1:0]});
			lv = $urandom % 6;
			vdd_below <= 5'h1F << lv;
			tick(4);
			e = live(c, lv);
			rdr(8'h1C);
			chk("live", rd & 32'h7, {29'h0, e});
			chk("rreq", cpu_reset_req, e[0]);
			chk("fblk", flash_block, e[2]);
			brownout_rst_flag |= e[0];
			brownout_irq_flag |= e[1];
			chk("ireq", brownout_irq_req, brownout_irq_flag);
			vdd_below <= 5'h0;
			tick(2);
		end
		rchk("rsrc", 8'h10, {25'h0, brownout_irq_flag[0], brownout_rst_flag[0], 5'h0});
		wr(8'h10, 32'h0);
		rchk("rsrc", 8'h10, 32'h0);
		rdr(8'h14);
		// Global enable off: flag sets, request stays low
		wr(8'h0C, 32'h20);
		vdd_below <= 5'h1F;
		tick(4);
		chk("ireq", brownout_irq_req, 0);
		vdd_below <= 5'h0;
		wr(8'h0C, 32'hA0);
		tick(2);
		chk("ireq", brownout_irq_req, 1);
		wr(8'h18, 32'h1);
		tick(2);
		chk("irq", irq, 1);
		rchk("stat", 8'h14, 32'h7);
		tick(2);
		chk("irq", irq, 0);
		wr(8'h10, 32'h0);
		// Total power-down ignores a deep trip
		wr(8'h00, 32'h13);
		vdd_below <= 5'h1F;
		tick(4);
		chk("rreq", cpu_reset_req, 0);
		chk("ireq", brownout_irq_req, 0);
		chk("cmp", cmp_disable, 1);
		chk("fblk", flash_block, 0);
		rchk("rsrc", 8'h10, 32'h0);
		vdd_below <= 5'h0;
		wr(8'h00, 32'h12);
		tick(2);
		chk("osc", {osc_stop, cmp_disable, pwr_mode}, 32'hA);
		wr(8'h00, 32'h01);
		rchk("pwr", 8'h00, 32'h1);
		wake_irq <= 1'h1;
		tick(4);
		wake_irq <= 1'h0;
		rchk("pwr", 8'h00, 32'h0);
		poweron_det <= 1'h1;
		tick(1);
		poweron_det <= 1'h0;
		tick(2);
		rchk("rsrc", 8'h10, 32'h30);
		wr(8'h10, 32'h0);
		rchk("rsrc", 8'h10, 32'h0);
		wr(8'h20, 32'hFF);
		chk("bresp", rs, pwr_mon_pkg::RESP_DECERR);
		rchk("unmap", 8'h20, 32'h0);
		chk("rresp", rs, pwr_mon_pkg::RESP_DECERR);
		test_done;
	end
endmodule
